// >>> design/rsfh_consts.vh
// Overview of operation
// - Read count over limit answers exception 2; a combined read count over the write limit is discarded
// - Read request: node, 0x03, address, count
// - Read answer: node, 0x03, count, data
// - Single write done first, then exact echo
// - Single write carries one 16-bit word only
// - Multi write: count byte 6, data from 7
// - Multi write answer echoes address and count
// - Write count over limit: discard, no answer
// - Combined: count byte 10, data from 11
// - Combined writes, reads, answers read data
// - Address bits 15..14 type, 13..0 parameter
// - Type 00 int16, 01 int32, 10 float
// - Start address type governs whole block
// - 32-bit values: two registers, high word first
// - Global node zero acts but never answers
// - Exception: node, code with bit 7, code
// - Fields high byte first, check low first
`ifndef RSFH_CONSTS_VH
`define RSFH_CONSTS_VH
`define RSFH_FC_RD_MULTI 8'h03
`define RSFH_FC_WR_SINGLE 8'h06
`define RSFH_FC_WR_MULTI 8'h10
`define RSFH_FC_RW_MULTI 8'h17
`define RSFH_FC_EXC_BIT 8'h80
`define RSFH_EXC_NONE 8'h00
`define RSFH_EXC_ILL_FUNC 8'h01
`define RSFH_EXC_ILL_ADDR 8'h02
`define RSFH_NODE_GLOBAL 8'h00
`define RSFH_TYPE_INT16 2'b00
`define RSFH_TYPE_INT32 2'b01
`define RSFH_TYPE_FLOAT 2'b10
`define RSFH_TYPE_RSVD 2'b11
`define RSFH_TYPE_MSB 15
`define RSFH_TYPE_LSB 14
`define RSFH_PADDR_MSB 13
`define RSFH_HLEN_STD 4'h6
`define RSFH_HLEN_WM 4'h7
`define RSFH_HLEN_RW 4'hb
`define RSFH_HDR_BYTES 11
`define RSFH_RSP_SHORT 3'h3
`define RSFH_RSP_ECHO 3'h6
`define RSFH_BYTES_W16 3'h2
`define RSFH_BYTES_W32 3'h4
`define RSFH_RD_MAX_DEF 16'h0010
`define RSFH_WR_MAX_DEF 16'h0010
`endif

// >>> design/rsfh_buf2.v
`timescale 1ns/1ps
// Two-entry buffer; a stalled receiver holds back the producer without losing a byte.
module rsfh_buf2 #(
    parameter W = 9
) (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    input wire ce,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [1:0] cnt_r;
    reg wp_r;
    reg rp_r;
    wire [W-1:0] ent [0:1];
    wire push = ce && in_valid && in_ready;
    wire pop = ce && out_valid && out_ready;

    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = ent[rp_r];

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ent
            reg [W-1:0] mem_r;
            always @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    mem_r <= {W{1'b0}};
                end else if (push && wp_r == g) begin
                    mem_r <= in_data;
                end
            end
            assign ent[g] = mem_r;
        end
    endgenerate

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 2'h0;
            wp_r <= 1'b0;
            rp_r <= 1'b0;
        end else begin
            if (push) begin
                wp_r <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 2'h1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 2'h1;
            end
        end
    end
endmodule

// >>> design/rsfh_handler.v
`timescale 1ns/1ps
`include "rsfh_consts.vh"
// Request bytes arrive CRC-checked and without CRC; response bytes leave without CRC.
// The downstream framer appends the check bytes, low byte first, right after tx_last.
module rsfh_handler #(
    parameter [15:0] RD_MAX = `RSFH_RD_MAX_DEF,
    parameter [15:0] WR_MAX = `RSFH_WR_MAX_DEF,
    parameter FLOAT_EN = 1
) (
    // Clock, reset, enable
    input wire core_clk,
    input wire rstn,
    input wire ce,
    // Configuration
    input wire [7:0] my_node,
    // Request byte stream
    input wire rx_valid,
    output wire rx_ready,
    input wire [7:0] rx_data,
    input wire rx_last,
    // Response byte stream
    output wire tx_valid,
    input wire tx_ready,
    output wire [7:0] tx_data,
    output wire tx_last,
    // Parameter store access
    output wire par_req,
    output wire par_we,
    output wire [1:0] par_type,
    output wire [13:0] par_addr,
    output wire [31:0] par_wdata,
    input wire par_ack,
    input wire [31:0] par_rdata
);
    localparam [7:0] ST_HDR = 8'h01;
    localparam [7:0] ST_CHK = 8'h02;
    localparam [7:0] ST_WDATA = 8'h04;
    localparam [7:0] ST_WACC = 8'h08;
    localparam [7:0] ST_DRAIN = 8'h10;
    localparam [7:0] ST_RESP = 8'h20;
    localparam [7:0] ST_RACC = 8'h40;
    localparam [7:0] ST_RDATA = 8'h80;

    reg [7:0] state_r;
    reg [3:0] idx_r;
    reg [7:0] hdr_r [0:`RSFH_HDR_BYTES-1];
    reg done_r;
    reg rsp_r;
    reg rd_after_r;
    reg [7:0] exc_r;
    reg [2:0] bi_r;
    reg [15:0] cnt_r;
    reg [13:0] addr_r;
    reg [1:0] type_r;
    reg wide_r;
    reg [2:0] nb_r;
    reg [31:0] sh_r;
    reg [31:0] wdat_r;
    integer i;

    function type_bad;
        input [1:0] t;
        begin
            type_bad = (t == `RSFH_TYPE_RSVD) || (t == `RSFH_TYPE_FLOAT && FLOAT_EN == 0);
        end
    endfunction

    function cnt_bad;
        input [15:0] c;
        input [1:0] t;
        begin
            cnt_bad = (c == 16'h0000) || (t != `RSFH_TYPE_INT16 && c[0]);
        end
    endfunction

    wire [7:0] fc = hdr_r[1];
    wire is_rd = (fc == `RSFH_FC_RD_MULTI);
    wire is_ws = (fc == `RSFH_FC_WR_SINGLE);
    wire is_wm = (fc == `RSFH_FC_WR_MULTI);
    wire is_rw = (fc == `RSFH_FC_RW_MULTI);
    wire sup_rx = (rx_data == `RSFH_FC_RD_MULTI) || (rx_data == `RSFH_FC_WR_SINGLE) ||
                  (rx_data == `RSFH_FC_WR_MULTI) || (rx_data == `RSFH_FC_RW_MULTI);
    wire [3:0] hlen = is_wm ? `RSFH_HLEN_WM : (is_rw ? `RSFH_HLEN_RW : `RSFH_HLEN_STD);
    wire hdr_full = (idx_r >= 4'h5) && (idx_r == hlen - 4'h1);

    // Field layout of the requests.
    wire [15:0] rd_addr = {hdr_r[2], hdr_r[3]};
    wire [15:0] rd_cnt = {hdr_r[4], hdr_r[5]};
    wire [15:0] wr_addr = is_rw ? {hdr_r[6], hdr_r[7]} : {hdr_r[2], hdr_r[3]};
    wire [15:0] wr_cnt = is_rw ? {hdr_r[8], hdr_r[9]} : {hdr_r[4], hdr_r[5]};
    wire [7:0] wr_bc = is_rw ? hdr_r[10] : hdr_r[6];
    wire [1:0] rd_type = rd_addr[`RSFH_TYPE_MSB:`RSFH_TYPE_LSB];
    wire [1:0] wr_type = wr_addr[`RSFH_TYPE_MSB:`RSFH_TYPE_LSB];
    wire rd_wide = (rd_type != `RSFH_TYPE_INT16);
    wire wr_wide = (wr_type != `RSFH_TYPE_INT16);
    wire rd_bad = type_bad(rd_type) || (rd_cnt > RD_MAX) || cnt_bad(rd_cnt, rd_type);
    wire bc_bad = ({9'h000, wr_bc} != {wr_cnt, 1'b0});
    wire wr_bad = type_bad(wr_type) || cnt_bad(wr_cnt, wr_type) || bc_bad;
    wire [15:0] rd_acc = rd_wide ? {1'b0, rd_cnt[15:1]} : rd_cnt;
    wire [15:0] wr_acc = wr_wide ? {1'b0, wr_cnt[15:1]} : wr_cnt;
    wire is_global = (hdr_r[0] == `RSFH_NODE_GLOBAL);
    wire is_mine = (hdr_r[0] == my_node);

    assign rx_ready = ce && ((state_r == ST_HDR) || (state_r == ST_WDATA) ||
                             (state_r == ST_DRAIN && !done_r));
    wire acc_rx = rx_valid && rx_ready;

    // Response header bytes.
    wire hdr_rsp = (exc_r == `RSFH_EXC_NONE) && (is_rd || is_rw);
    wire [2:0] rlen = (exc_r != `RSFH_EXC_NONE || is_rd || is_rw) ? `RSFH_RSP_SHORT : `RSFH_RSP_ECHO;
    reg [7:0] rsp_byte;
    always @* begin
        case (bi_r)
            3'h0: rsp_byte = my_node;
            3'h1: rsp_byte = (exc_r != `RSFH_EXC_NONE) ? (fc | `RSFH_FC_EXC_BIT) : fc;
            3'h2: rsp_byte = (exc_r != `RSFH_EXC_NONE) ? exc_r :
                             (hdr_rsp ? {rd_cnt[6:0], 1'b0} : hdr_r[2]);
            3'h3: rsp_byte = hdr_r[3];
            3'h4: rsp_byte = hdr_r[4];
            3'h5: rsp_byte = hdr_r[5];
            default: rsp_byte = 8'h00;
        endcase
    end

    wire in_rsp = (state_r == ST_RESP);
    wire in_rdat = (state_r == ST_RDATA);
    wire push_v = ce && (in_rsp || in_rdat);
    wire push_rdy;
    wire push = push_v && push_rdy;
    wire [7:0] push_d = in_rsp ? rsp_byte : sh_r[31:24];
    wire push_last = in_rsp ? (bi_r == rlen - 3'h1 && !hdr_rsp) : (nb_r == 3'h1 && cnt_r == 16'h0000);

    assign par_req = (state_r == ST_WACC) || (state_r == ST_RACC);
    assign par_we = (state_r == ST_WACC);
    assign par_type = type_r;
    assign par_addr = addr_r;
    assign par_wdata = wdat_r;
    wire acc_done = ce && par_req && par_ack;

    rsfh_buf2 #(
        .W(9)
    ) u_buf (
        .core_clk(core_clk),
        .rstn(rstn),
        .ce(ce),
        .in_valid(push_v),
        .in_ready(push_rdy),
        .in_data({push_last, push_d}),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data({tx_last, tx_data})
    );

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_HDR;
            idx_r <= 4'h0;
            for (i = 0; i < `RSFH_HDR_BYTES; i = i + 1) begin
                hdr_r[i] <= 8'h00;
            end
            done_r <= 1'b0;
            rsp_r <= 1'b0;
            rd_after_r <= 1'b0;
            exc_r <= `RSFH_EXC_NONE;
            bi_r <= 3'h0;
            cnt_r <= 16'h0000;
            addr_r <= 14'h0000;
            type_r <= `RSFH_TYPE_INT16;
            wide_r <= 1'b0;
            nb_r <= 3'h0;
            sh_r <= 32'h0000_0000;
            wdat_r <= 32'h0000_0000;
        end else if (ce) begin
            if (acc_rx && rx_last && state_r != ST_HDR) begin
                done_r <= 1'b1;
            end
            case (state_r)
                ST_HDR: begin
                    done_r <= acc_rx && rx_last;
                    exc_r <= `RSFH_EXC_NONE;
                    bi_r <= 3'h0;
                    if (acc_rx) begin
                        hdr_r[idx_r] <= rx_data;
                        idx_r <= idx_r + 4'h1;
                        if (idx_r == 4'h1 && !sup_rx) begin
                            exc_r <= `RSFH_EXC_ILL_FUNC;
                            rsp_r <= is_mine;
                            state_r <= ST_DRAIN;
                        end else if (hdr_full) begin
                            state_r <= ST_CHK;
                        end else if (rx_last) begin
                            idx_r <= 4'h0;
                        end
                    end
                end
                ST_CHK: begin
                    rsp_r <= is_mine;
                    rd_after_r <= 1'b0;
                    state_r <= ST_DRAIN;
                    if (!is_mine && !is_global) begin
                        rsp_r <= 1'b0;
                    end else if (is_rd) begin
                        if (rd_bad) begin
                            exc_r <= `RSFH_EXC_ILL_ADDR;
                        end else begin
                            cnt_r <= rd_acc;
                            addr_r <= rd_addr[`RSFH_PADDR_MSB:0];
                            type_r <= rd_type;
                            wide_r <= rd_wide;
                        end
                    end else if (is_ws) begin
                        if (type_bad(wr_type)) begin
                            exc_r <= `RSFH_EXC_ILL_ADDR;
                        end else begin
                            cnt_r <= 16'h0001;
                            addr_r <= wr_addr[`RSFH_PADDR_MSB:0];
                            type_r <= wr_type;
                            wdat_r <= {{16{hdr_r[4][7]}}, hdr_r[4], hdr_r[5]};
                            state_r <= ST_WACC;
                        end
                    end else if (wr_cnt > WR_MAX || (is_rw && rd_cnt > WR_MAX)) begin
                        rsp_r <= 1'b0;
                    end else if (wr_bad || (is_rw && rd_bad)) begin
                        exc_r <= `RSFH_EXC_ILL_ADDR;
                    end else begin
                        cnt_r <= wr_acc;
                        addr_r <= wr_addr[`RSFH_PADDR_MSB:0];
                        type_r <= wr_type;
                        wide_r <= wr_wide;
                        nb_r <= wr_wide ? `RSFH_BYTES_W32 : `RSFH_BYTES_W16;
                        rd_after_r <= is_rw;
                        state_r <= ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    if (acc_rx) begin
                        sh_r <= {sh_r[23:0], rx_data};
                        nb_r <= nb_r - 3'h1;
                        if (nb_r == 3'h1) begin
                            wdat_r <= wide_r ? {sh_r[23:0], rx_data} :
                                      {{16{sh_r[7]}}, sh_r[7:0], rx_data};
                            state_r <= ST_WACC;
                        end else if (rx_last) begin
                            rsp_r <= 1'b0;
                            state_r <= ST_DRAIN;
                        end
                    end
                end
                ST_WACC: begin
                    if (acc_done) begin
                        addr_r <= addr_r + 14'h0001;
                        cnt_r <= cnt_r - 16'h0001;
                        nb_r <= wide_r ? `RSFH_BYTES_W32 : `RSFH_BYTES_W16;
                        if (cnt_r != 16'h0001 && done_r) begin
                            // A frame cut short at a word boundary keeps that word but gets no answer.
                            rsp_r <= 1'b0;
                            state_r <= ST_DRAIN;
                        end else if (cnt_r != 16'h0001) begin
                            state_r <= ST_WDATA;
                        end else begin
                            state_r <= ST_DRAIN;
                            if (rd_after_r) begin
                                cnt_r <= rd_acc;
                                addr_r <= rd_addr[`RSFH_PADDR_MSB:0];
                                type_r <= rd_type;
                                wide_r <= rd_wide;
                            end
                        end
                    end
                end
                ST_DRAIN: begin
                    if (done_r) begin
                        done_r <= 1'b0;
                        idx_r <= 4'h0;
                        state_r <= rsp_r ? ST_RESP : ST_HDR;
                    end
                end
                ST_RESP: begin
                    if (push) begin
                        bi_r <= bi_r + 3'h1;
                        if (bi_r == rlen - 3'h1) begin
                            state_r <= hdr_rsp ? ST_RACC : ST_HDR;
                        end
                    end
                end
                ST_RACC: begin
                    if (acc_done) begin
                        sh_r <= wide_r ? par_rdata : {par_rdata[15:0], 16'h0000};
                        nb_r <= wide_r ? `RSFH_BYTES_W32 : `RSFH_BYTES_W16;
                        addr_r <= addr_r + 14'h0001;
                        cnt_r <= cnt_r - 16'h0001;
                        state_r <= ST_RDATA;
                    end
                end
                ST_RDATA: begin
                    if (push) begin
                        sh_r <= {sh_r[23:0], 8'h00};
                        nb_r <= nb_r - 3'h1;
                        if (nb_r == 3'h1) begin
                            state_r <= (cnt_r == 16'h0000) ? ST_HDR : ST_RACC;
                        end
                    end
                end
                default: begin
                    state_r <= ST_HDR;
                end
            endcase
        end
    end
endmodule

// >>> verif/rsfh_handler_chk.sv
`timescale 1ns/1ps
module rsfh_handler_chk #(
    parameter [15:0] RD_MAX = 16'h0010,
    parameter [15:0] WR_MAX = 16'h0010,
    parameter FLOAT_EN = 1
) (
    // Clock, reset, enable
    input wire core_clk,
    input wire rstn,
    input wire ce,
    // Streams
    input wire rx_ready,
    input wire tx_valid,
    input wire tx_ready,
    input wire [7:0] tx_data,
    input wire tx_last,
    // Parameter store
    input wire par_req,
    input wire par_we,
    input wire [1:0] par_type,
    input wire [13:0] par_addr,
    input wire [31:0] par_wdata,
    input wire par_ack
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_par_wait;
        par_req && !par_ack;
    endsequence
    sequence s_tx_wait;
        tx_valid && !tx_ready;
    endsequence

    AST_PAR_HOLD: assert property (s_par_wait |=> par_req)
        else $error("access request dropped before ack");
    AST_PAR_STABLE: assert property (s_par_wait |=> $stable(par_we) && $stable(par_addr)
        && $stable(par_type) && $stable(par_wdata))
        else $error("access qualifiers moved before ack");
    AST_TX_HOLD: assert property (s_tx_wait |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("response byte changed while stalled");
    AST_NO_RSVD: assert property (par_req |-> par_type != 2'b11)
        else $error("reserved type reached the store");
    AST_SEXT: assert property (par_req && par_we && par_type == 2'b00
        |-> par_wdata[31:16] == {16{par_wdata[15]}})
        else $error("16-bit write not sign extended");
    AST_RX_BLOCKED: assert property (par_req |-> !rx_ready)
        else $error("request bytes taken during access");
    AST_CE_FREEZE: assert property (!ce |-> !rx_ready)
        else $error("bytes taken while disabled");
    AST_RST_QUIET: assert property ($rose(rstn) |-> !tx_valid && !tx_last && !par_req)
        else $error("outputs busy after reset");
endmodule

bind rsfh_handler rsfh_handler_chk #(.RD_MAX(RD_MAX), .WR_MAX(WR_MAX), .FLOAT_EN(FLOAT_EN)) chk_i (.*);

// >>> verif/rsfh_par_store.sv
`timescale 1ns/1ps
// Parameter store model; the bench sets the ack latency so prompt and slow answers both occur.
module rsfh_par_store (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    // Access
    input wire par_req,
    input wire par_we,
    input wire [1:0] par_type,
    input wire [13:0] par_addr,
    input wire [31:0] par_wdata,
    input wire [3:0] lat,
    output reg par_ack,
    output wire [31:0] par_rdata
);
    reg [31:0] mem [0:63];
    reg [31:0] rd_r;
    reg [31:0] junk_r;
    reg [3:0] wait_r;
    reg [1:0] last_type;
    integer wr_cnt = 0;
    // Outside an ack the data lines move every cycle, so stale data never looks like an answer.
    assign par_rdata = par_ack ? rd_r : junk_r;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            par_ack <= 1'b0;
            wait_r <= 4'h0;
            junk_r <= 32'h5A5A_5A5A;
        end else begin
            junk_r <= {junk_r[30:0], ~junk_r[31]};
            par_ack <= 1'b0;
            if (par_req && !par_ack) begin
                if (wait_r >= lat) begin
                    par_ack <= 1'b1;
                    wait_r <= 4'h0;
                    last_type <= par_type;
                    if (par_we) begin
                        mem[par_addr[5:0]] <= par_wdata;
                        wr_cnt <= wr_cnt + 1;
                    end else begin
                        rd_r <= mem[par_addr[5:0]];
                    end
                end else begin
                    wait_r <= wait_r + 4'h1;
                end
            end
        end
    end
endmodule

// >>> verif/tb_rsfh_handler.sv
`timescale 1ns/1ps
module tb_rsfh_handler;
    typedef logic [7:0] rsfh_bq_t [$];
    logic core_clk, rstn, ce, rx_valid, rx_last, tx_ready, hold, stall, got_last;
    logic [7:0] my_node, rx_data;
    logic [3:0] lat;
    wire rx_ready, tx_valid, tx_last, par_req, par_we, par_ack;
    wire [7:0] tx_data;
    wire [1:0] par_type;
    wire [13:0] par_addr;
    wire [31:0] par_wdata, par_rdata;
    logic [7:0] rq [$];
    integer bad_count, tests_run, first_wr, i;

    rsfh_handler #(.RD_MAX(16'h0010), .WR_MAX(16'h0010), .FLOAT_EN(1)) rsfh_handler_i (.*);
    rsfh_par_store rsfh_par_store_i (.*);

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    function [31:0] pv(input integer k);
        pv = 32'h8C30_0000 + k * 32'h0000_1357;
    endfunction

    always @(negedge core_clk) tx_ready <= hold ? 1'b0 : (stall ? ~tx_ready : 1'b1);

    always @(posedge core_clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (rq.size() == 0) first_wr = rsfh_par_store_i.wr_cnt;
            rq.push_back(tx_data);
            if (tx_last === 1'b1) got_last = 1'b1;
        end
    end

    task cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task send(input rsfh_bq_t f);
        integer k, n;
        for (k = 0; k < f.size(); k++) begin
            @(negedge core_clk);
            rx_valid = 1'b1;
            rx_data = f[k];
            rx_last = (k == f.size() - 1);
            n = 0;
            while (rx_ready !== 1'b1 && n < 500) begin
                @(negedge core_clk);
                n++;
            end
            cmp8({7'h00, rx_ready}, 8'h01, "byte refused");
        end
        @(negedge core_clk);
        rx_valid = 1'b0;
        rx_last = 1'b0;
        rx_data = ~rx_data;
    endtask

    task chk_rsp(input rsfh_bq_t e);
        integer k, n;
        n = 0;
        while (got_last !== 1'b1 && n < 2000) begin
            @(negedge core_clk);
            n++;
        end
        cmp32(rq.size(), e.size(), "resp length");
        for (k = 0; k < e.size() && k < rq.size(); k++) cmp8(rq[k], e[k], "resp byte");
        rq.delete();
        got_last = 1'b0;
    endtask

    // A silent slave can only be judged by waiting well past any answer it could give.
    task chk_none;
        repeat (150) @(negedge core_clk);
        cmp32(rq.size(), 0, "unexpected response");
        rq.delete();
        got_last = 1'b0;
    endtask

    task t_read;
        integer t, k;
        logic [31:0] v;
        rsfh_bq_t e;
        for (t = 0; t < 3; t++) begin
            stall = (t == 1);
            lat = 4'(t * 2);
            send('{8'h08, 8'h03, {t[1:0], 6'h00}, 8'h04, 8'h00, (t == 0) ? 8'h02 : 8'h04});
            e = '{8'h08, 8'h03, (t == 0) ? 8'h04 : 8'h08};
            for (k = 4; k < 6; k++) begin
                v = pv(k);
                if (t != 0) e = {e, v[31:24], v[23:16]};
                e = {e, v[15:8], v[7:0]};
            end
            chk_rsp(e);
            cmp8({6'h00, rsfh_par_store_i.last_type}, t[7:0], "type");
        end
        stall = 1'b0;
    endtask

    task t_hold;
        rsfh_bq_t e;
        logic [31:0] v;
        hold = 1'b1;
        send('{8'h08, 8'h03, 8'h00, 8'h00, 8'h00, 8'h08});
        repeat (40) @(negedge core_clk);
        cmp8({7'h00, tx_valid}, 8'h01, "stalled output");
        ce = 1'b0;
        @(negedge core_clk);
        cmp8({7'h00, rx_ready}, 8'h00, "disabled intake");
        ce = 1'b1;
        hold = 1'b0;
        e = '{8'h08, 8'h03, 8'h10};
        for (i = 0; i < 8; i++) begin
            v = pv(i);
            e = {e, v[15:8], v[7:0]};
        end
        chk_rsp(e);
        // In the header state intake is open, so only the enable can close it here.
        ce = 1'b0;
        @(negedge core_clk);
        cmp8({7'h00, rx_ready}, 8'h00, "disabled header intake");
        ce = 1'b1;
    endtask

    task t_exc;
        send('{8'h08, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01});
        chk_rsp('{8'h08, 8'h85, 8'h01});
        send('{8'h08, 8'h03, 8'hC0, 8'h04, 8'h00, 8'h02});
        chk_rsp('{8'h08, 8'h83, 8'h02});
        send('{8'h08, 8'h03, 8'h40, 8'h04, 8'h00, 8'h01});
        chk_rsp('{8'h08, 8'h83, 8'h02});
        send('{8'h08, 8'h03, 8'h00, 8'h00, 8'h00, 8'h11});
        chk_rsp('{8'h08, 8'h83, 8'h02});
        send('{8'h08, 8'h10, 8'h00, 8'h30, 8'h00, 8'h02, 8'h06, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06});
        chk_rsp('{8'h08, 8'h90, 8'h02});
        cmp32(rsfh_par_store_i.mem[48], pv(48), "refused block wrote");
    endtask

    task t_write;
        integer w;
        w = rsfh_par_store_i.wr_cnt;
        send('{8'h08, 8'h06, 8'h00, 8'h10, 8'hAB, 8'hCD});
        chk_rsp('{8'h08, 8'h06, 8'h00, 8'h10, 8'hAB, 8'hCD});
        cmp32(first_wr, w + 1, "write before echo");
        cmp32(rsfh_par_store_i.mem[16], 32'hFFFF_ABCD, "single write");
        send('{8'h08, 8'h06, 8'h40, 8'h11, 8'h12, 8'h34});
        chk_rsp('{8'h08, 8'h06, 8'h40, 8'h11, 8'h12, 8'h34});
        cmp32(rsfh_par_store_i.mem[17], 32'h0000_1234, "single write 32");
        send('{8'h08, 8'h10, 8'h40, 8'h20, 8'h00, 8'h04, 8'h08,
               8'h11, 8'h22, 8'h33, 8'h44, 8'hA5, 8'hB6, 8'hC7, 8'hD8});
        chk_rsp('{8'h08, 8'h10, 8'h40, 8'h20, 8'h00, 8'h04});
        cmp32(rsfh_par_store_i.mem[32], 32'h1122_3344, "block word 0");
        cmp32(rsfh_par_store_i.mem[33], 32'hA5B6_C7D8, "block word 1");
    endtask

    task t_silent;
        rsfh_bq_t f;
        f = '{8'h08, 8'h10, 8'h00, 8'h00, 8'h00, 8'h11, 8'h22};
        for (i = 0; i < 34; i++) f.push_back(i[7:0]);
        send(f);
        chk_none();
        cmp32(rsfh_par_store_i.mem[0], pv(0), "discarded block wrote");
        send('{8'h00, 8'h06, 8'h00, 8'h18, 8'h00, 8'h55});
        chk_none();
        cmp32(rsfh_par_store_i.mem[24], 32'h0000_0055, "global write");
        send('{8'h09, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01});
        chk_none();
    endtask

    task t_rw;
        lat = 4'h1;
        send('{8'h08, 8'h17, 8'h00, 8'h30, 8'h00, 8'h01, 8'h00, 8'h30, 8'h00, 8'h01, 8'h02, 8'h13, 8'h57});
        chk_rsp('{8'h08, 8'h17, 8'h02, 8'h13, 8'h57});
        cmp32(rsfh_par_store_i.mem[48], 32'h0000_1357, "combined write");
    endtask

    task close_out;
        if (bad_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // The whole sequence needs about a thousand cycles; this span leaves a wide margin.
    initial begin
        #200000;
        bad_count++;
        close_out();
    end

    initial begin
        bad_count = 0;
        tests_run = 0;
        rstn = 1'b0;
        ce = 1'b1;
        my_node = 8'h08;
        rx_valid = 1'b0;
        rx_last = 1'b0;
        rx_data = 8'h00;
        hold = 1'b0;
        stall = 1'b0;
        got_last = 1'b0;
        lat = 4'h0;
        for (i = 0; i < 64; i++) rsfh_par_store_i.mem[i] = pv(i);
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        rstn = 1'b1;
        t_read();
        t_hold();
        t_exc();
        t_write();
        @(negedge core_clk);
        rstn = 1'b0;
        repeat (3) @(negedge core_clk);
        rstn = 1'b1;
        t_silent();
        t_rw();
        close_out();
    end
endmodule
